// ===== rtl/asrc_pkg.sv
// package: pin timing and sizes for the static memory host controller
// assumes a 100 MHz core clock and a memory of the slower speed grade
package asrc_pkg;
    localparam int ADDR_W = 18;
    localparam int DATA_W = 4;
    localparam int CLK_PERIOD_PS = 10000;
    // times in picoseconds
    localparam int ADDR_ACCESS_DELAY_PS = 7000;
    localparam int OE_ACCESS_DELAY_PS = 4000;
    localparam int OE_TO_FLOAT_MAX_PS = 3500;
    localparam int WRITE_PULSE_MIN_PS = 7000;
    localparam int DATA_SETUP_TO_WRITE_END_PS = 3500;
    localparam int WRITE_END_TO_DRIVE_MIN_PS = 3000;
    localparam int CYCLE_PERIOD_MIN_PS = 7000;
    // round up to whole cycles, never under one
    function automatic int asrc_cyc(input int ps);
        int c;
        c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
        return (c < 1) ? 1 : c;
    endfunction : asrc_cyc
    localparam int RD_WAIT_CYC = asrc_cyc(ADDR_ACCESS_DELAY_PS) + 1;
    localparam int WR_PULSE_CYC = asrc_cyc(WRITE_PULSE_MIN_PS);
    localparam int TURN_CYC = asrc_cyc(OE_TO_FLOAT_MAX_PS);
    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] CNT_RST = 4'h0;
    typedef enum logic [2:0]
    {
        ASRC_IDLE = 3'b000,
        ASRC_SETUP = 3'b001,
        ASRC_ACTIVE = 3'b011,
        ASRC_DONE = 3'b010,
        ASRC_TURN = 3'b110
    } asrc_state_t;
endpackage : asrc_pkg

// ===== rtl/asrc_if.sv
// interface: pin-side signals between sequencer and pin stage
// assumes one core clock domain
`timescale 1ns/1ps
interface asrc_pin_if;
    import asrc_pkg::*;
    logic [ADDR_W-1:0] addr;
    logic              sel_n;
    logic              oe_n;
    logic              we_n;
    logic [DATA_W-1:0] wdata;
    logic              drive;
    logic [DATA_W-1:0] rdata_sync;
    modport seq (output addr, sel_n, oe_n, we_n, wdata, drive, input rdata_sync);
    modport pins (input addr, sel_n, oe_n, we_n, wdata, drive, output rdata_sync);
endinterface : asrc_pin_if

// ===== rtl/asrc_pins.sv
// pin stage: registered pin outputs and two-stage sync of read data
// assumes reset already synchronised to core clock
`timescale 1ns/1ps
module asrc_pins
(
    // clock and reset
    input  wire logic                            clk_i,
    input  wire logic                            rst_n_i,
    // sequencer side
    asrc_pin_if.pins                             pif,
    // memory pins
    output logic [asrc_pkg::ADDR_W-1:0]          word_select_bus_o,
    output logic                                 sel_n_o,
    output logic                                 oe_n_o,
    output logic                                 we_n_o,
    input  wire logic [asrc_pkg::DATA_W-1:0]     bidir_data_bus_i,
    output logic [asrc_pkg::DATA_W-1:0]          bidir_data_bus_o,
    output logic                                 bidir_data_bus_oe_o
);
    import asrc_pkg::*;
    logic [DATA_W-1:0] meta_r;
    logic [DATA_W-1:0] sync_r;

    // registered strobes, idle high
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            word_select_bus_o <= '0;
            sel_n_o <= 1'b1;
            oe_n_o <= 1'b1;
            we_n_o <= 1'b1;
            bidir_data_bus_o <= '0;
            bidir_data_bus_oe_o <= 1'b0;
        end
        else
        begin
            word_select_bus_o <= pif.addr;
            sel_n_o <= pif.sel_n;
            oe_n_o <= pif.oe_n;
            we_n_o <= pif.we_n;
            bidir_data_bus_o <= pif.wdata;
            bidir_data_bus_oe_o <= pif.drive;
        end
    end

    // two flops on the returning data
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            meta_r <= '0;
            sync_r <= '0;
        end
        else
        begin
            meta_r <= bidir_data_bus_i;
            sync_r <= meta_r;
        end
    end
    assign pif.rdata_sync = sync_r;
endmodule : asrc_pins

// ===== rtl/asrc_ctrl.sv
// top: host controller driving an asynchronous static memory
// assumes a single 100 MHz clock; memory outputs are registered once, read data twice
`timescale 1ns/1ps
module asrc_ctrl
(
    // clock and reset
    input  wire logic                            core_clk_i,
    input  wire logic                            resetn_i,
    // request port
    input  wire logic                            req_valid_i,
    output logic                                 req_ready_o,
    input  wire logic                            req_write_i,
    input  wire logic [asrc_pkg::ADDR_W-1:0]     req_addr_i,
    input  wire logic [asrc_pkg::DATA_W-1:0]     req_wdata_i,
    // answer port
    output logic                                 rsp_valid_o,
    output logic [asrc_pkg::DATA_W-1:0]          rsp_rdata_o,
    // memory pins
    output logic [asrc_pkg::ADDR_W-1:0]          word_select_bus_o,
    output logic                                 sel_n_o,
    output logic                                 oe_n_o,
    output logic                                 we_n_o,
    input  wire logic [asrc_pkg::DATA_W-1:0]     bidir_data_bus_i,
    output logic [asrc_pkg::DATA_W-1:0]          bidir_data_bus_o,
    output logic                                 bidir_data_bus_oe_o
);
    import asrc_pkg::*;

    // ****************************************
    // reset release
    // ****************************************
    logic rst_meta_r;
    logic rst_n_r;
    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            rst_meta_r <= 1'b0;
            rst_n_r <= 1'b0;
        end
        else
        begin
            rst_meta_r <= 1'b1;
            rst_n_r <= rst_meta_r;
        end
    end

    // ****************************************
    // sequencer state
    // ****************************************
    asrc_pin_if pif ();
    asrc_state_t       state_r;
    asrc_state_t       state_nxt;
    logic [CNT_W-1:0]  cnt_r;
    logic              write_r;
    logic [ADDR_W-1:0] addr_r;
    logic [DATA_W-1:0] wdata_r;
    logic              cnt_done;

    assign cnt_done = (cnt_r == CNT_RST);
    // nothing is taken while the sequencer is still held in reset
    assign req_ready_o = rst_n_r && (state_r == ASRC_IDLE);

    // next state
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            ASRC_IDLE:   if (req_valid_i) state_nxt = ASRC_SETUP;
            ASRC_SETUP:  state_nxt = ASRC_ACTIVE;
            ASRC_ACTIVE: if (cnt_done) state_nxt = ASRC_DONE;
            ASRC_DONE:   state_nxt = ASRC_TURN;
            ASRC_TURN:   if (cnt_done) state_nxt = ASRC_IDLE;
            default:     state_nxt = ASRC_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_i or negedge rst_n_r)
    begin
        if (!rst_n_r)
            state_r <= ASRC_IDLE;
        else
            state_r <= state_nxt;
    end

    // phase counter, loaded with rounded-up cycle counts minus one
    always_ff @(posedge core_clk_i or negedge rst_n_r)
    begin
        if (!rst_n_r)
            cnt_r <= CNT_RST;
        else if (state_r == ASRC_SETUP)
            cnt_r <= write_r ? CNT_W'(WR_PULSE_CYC - 1) : CNT_W'(RD_WAIT_CYC - 1);
        else if (state_r == ASRC_DONE)
            cnt_r <= CNT_W'(TURN_CYC - 1);
        else if (!cnt_done)
            cnt_r <= cnt_r - 4'h1;
    end

    // latched request
    always_ff @(posedge core_clk_i or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            write_r <= 1'b0;
            addr_r <= '0;
            wdata_r <= '0;
        end
        else if (req_valid_i && req_ready_o)
        begin
            write_r <= req_write_i;
            addr_r <= req_addr_i;
            wdata_r <= req_wdata_i;
        end
    end

    // ****************************************
    // pin requests
    // ****************************************
    logic active;
    assign active = (state_r == ASRC_ACTIVE);
    assign pif.addr = addr_r;
    assign pif.sel_n = !active;
    assign pif.we_n = !(active && write_r);
    assign pif.oe_n = !(active && !write_r);
    assign pif.drive = (active || state_r == ASRC_DONE) && write_r;
    assign pif.wdata = wdata_r;

    asrc_pins asrc_pins_i
    (
        .clk_i               (core_clk_i),
        .rst_n_i             (rst_n_r),
        .pif                 (pif),
        .word_select_bus_o   (word_select_bus_o),
        .sel_n_o             (sel_n_o),
        .oe_n_o              (oe_n_o),
        .we_n_o              (we_n_o),
        .bidir_data_bus_i    (bidir_data_bus_i),
        .bidir_data_bus_o    (bidir_data_bus_o),
        .bidir_data_bus_oe_o (bidir_data_bus_oe_o)
    );

    // ****************************************
    // read answer
    // ****************************************
    // sample in the turn cycle: sync then holds the bus from the second-last edge with
    // output enable low, well past the access delay
    always_ff @(posedge core_clk_i or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            rsp_valid_o <= 1'b0;
            rsp_rdata_o <= '0;
        end
        else
        begin
            rsp_valid_o <= (state_r == ASRC_TURN) && !write_r;
            if ((state_r == ASRC_TURN) && !write_r)
                rsp_rdata_o <= pif.rdata_sync;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    property p_no_write_in_read;
        @(posedge core_clk_i) disable iff (!rst_n_r)
        !oe_n_o |-> we_n_o;
    endproperty
    a_no_write_in_read: assert property (p_no_write_in_read) else $error("write enable low during read");

    // cycles spent with write enable low, for the pulse check
    logic [CNT_W-1:0] we_low_cnt_r;
    always_ff @(posedge core_clk_i or negedge rst_n_r)
    begin
        if (!rst_n_r)
            we_low_cnt_r <= CNT_RST;
        else if (we_n_o)
            we_low_cnt_r <= CNT_RST;
        else if (we_low_cnt_r != 4'hf)
            we_low_cnt_r <= we_low_cnt_r + 4'h1;
    end

    property p_write_pulse;
        @(posedge core_clk_i) disable iff (!rst_n_r)
        $rose(we_n_o) |-> (we_low_cnt_r >= CNT_W'(WR_PULSE_CYC));
    endproperty
    a_write_pulse: assert property (p_write_pulse) else $error("write pulse too short");

    property p_data_before_end;
        @(posedge core_clk_i) disable iff (!rst_n_r)
        $rose(we_n_o) |-> $past(bidir_data_bus_oe_o) && bidir_data_bus_oe_o;
    endproperty
    a_data_before_end: assert property (p_data_before_end) else $error("data not held to write end");

    property p_wdata_stable;
        @(posedge core_clk_i) disable iff (!rst_n_r)
        bidir_data_bus_oe_o && $past(bidir_data_bus_oe_o) |-> $stable(bidir_data_bus_o);
    endproperty
    a_wdata_stable: assert property (p_wdata_stable) else $error("write data moved while driven");

    property p_addr_stable;
        @(posedge core_clk_i) disable iff (!rst_n_r)
        !sel_n_o && !$fell(sel_n_o) |-> $stable(word_select_bus_o);
    endproperty
    a_addr_stable: assert property (p_addr_stable) else $error("address moved while selected");

    property p_sel_overlap;
        @(posedge core_clk_i) disable iff (!rst_n_r)
        !we_n_o |-> !sel_n_o;
    endproperty
    a_sel_overlap: assert property (p_sel_overlap) else $error("write without select");

    property p_no_drive_in_read;
        @(posedge core_clk_i) disable iff (!rst_n_r)
        !oe_n_o |-> !bidir_data_bus_oe_o;
    endproperty
    a_no_drive_in_read: assert property (p_no_drive_in_read) else $error("host drives during read");

    property p_turnaround;
        @(posedge core_clk_i) disable iff (!rst_n_r)
        $rose(sel_n_o) |-> sel_n_o [*2];
    endproperty
    a_turnaround: assert property (p_turnaround) else $error("cycle too short");

    property p_read_answer;
        @(posedge core_clk_i) disable iff (!rst_n_r)
        $fell(oe_n_o) |-> ##[3:4] rsp_valid_o;
    endproperty
    a_read_answer: assert property (p_read_answer) else $error("read answer late");
endmodule : asrc_ctrl

// ===== verif/asrc_mem_model.sv
// model: asynchronous static memory facing the host pins
// assumes active low strobes and a shared 4-bit data bus
`timescale 1ns/1ps
module asrc_mem_model
(
    // memory pins
    input  wire logic [17:0] addr_i,
    input  wire logic        sel_n_i,
    input  wire logic        oe_n_i,
    input  wire logic        we_n_i,
    input  wire logic [3:0]  bus_i,
    // memory output side
    output logic [3:0]       dq_o,
    output logic             drive_o
);
    logic [3:0] mem [0:262143];
    logic       rd;
    initial
    begin
        dq_o = 4'h0;
        drive_o = 1'b0;
    end
    // store while select and write overlap
    always @(*)
    begin
        if (!sel_n_i && !we_n_i)
            mem[addr_i] = bus_i;
    end
    // read mode decode, write wins
    assign rd = !sel_n_i && !oe_n_i && we_n_i;
    // drive turns on and off after the same 3 delay; floated lines show junk
    always @(rd or addr_i)
    begin
        if (rd)
        begin
            dq_o <= #2 ~dq_o;
            dq_o <= #4 mem[addr_i];
            drive_o <= #3 1'b1;
        end
        else
        begin
            drive_o <= #3 1'b0;
            dq_o <= #3 ~dq_o;
        end
    end
endmodule : asrc_mem_model

// ===== verif/asrc_ctrl_bench.sv
// bench: host controller against a behavioural memory
// assumes 100 MHz clock and one request at a time
`timescale 1ns/1ps
module asrc_ctrl_bench;
    import asrc_pkg::*;
    logic        core_clk_i = 1'b0;
    logic        resetn_i = 1'b0;
    logic        req_valid_i = 1'b0;
    logic        req_write_i = 1'b0;
    logic [17:0] req_addr_i = 18'h0;
    logic [3:0]  req_wdata_i = 4'h0;
    logic        req_ready_o, rsp_valid_o, sel_n_o, oe_n_o, we_n_o, bus_oe, mem_drive;
    logic [3:0]  rsp_rdata_o, bus_o, bus_i, mem_dq, q;
    logic [17:0] word_select_bus_o;
    int          fail_count = 0;
    int          total_checks = 0;
    logic [17:0] at [4] = '{18'h00000, 18'h3ffff, 18'h15555, 18'h2aaaa};
    logic [3:0]  dt [4] = '{4'h5, 4'ha, 4'hf, 4'h0};
    always #5 core_clk_i = ~core_clk_i;
    // wire level: host drive else memory side
    assign bus_i = bus_oe ? bus_o : mem_dq;
    asrc_ctrl asrc_ctrl_i (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .req_valid_i(req_valid_i),
        .req_ready_o(req_ready_o), .req_write_i(req_write_i), .req_addr_i(req_addr_i),
        .req_wdata_i(req_wdata_i), .rsp_valid_o(rsp_valid_o), .rsp_rdata_o(rsp_rdata_o),
        .word_select_bus_o(word_select_bus_o), .sel_n_o(sel_n_o), .oe_n_o(oe_n_o), .we_n_o(we_n_o),
        .bidir_data_bus_i(bus_i), .bidir_data_bus_o(bus_o), .bidir_data_bus_oe_o(bus_oe));
    asrc_mem_model asrc_mem_model_i (.addr_i(word_select_bus_o), .sel_n_i(sel_n_o), .oe_n_i(oe_n_o),
        .we_n_i(we_n_o), .bus_i(bus_i), .dq_o(mem_dq), .drive_o(mem_drive));
    task automatic check(input logic ok, input string msg);
        total_checks++;
        if (ok !== 1'b1)
        begin
            $display("[FAIL] %0t %s", $time, msg);
            fail_count++;
        end
    endtask : check
    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_sim
    // pin watch every cycle
    always @(negedge core_clk_i)
    begin
        if (resetn_i)
        begin
            check((we_n_o | oe_n_o) === 1'b1, "write and read strobes together");
            check((bus_oe & mem_drive) === 1'b0, "data bus contention");
        end
    end
    // one request, wait for completion, watch write pins
    task automatic req(input logic wr, input logic [17:0] a, input logic [3:0] d);
        int n;
        @(posedge core_clk_i);
        req_valid_i <= 1'b1;
        req_write_i <= wr;
        req_addr_i <= a;
        req_wdata_i <= d;
        n = 0;
        do
        begin
            @(negedge core_clk_i);
            n++;
        end while (req_ready_o !== 1'b1 && n < 20);
        @(posedge core_clk_i);
        req_valid_i <= 1'b0;
        n = 0;
        do
        begin
            @(negedge core_clk_i);
            n++;
            if (we_n_o === 1'b0)
                check({sel_n_o, bus_oe, bus_o, word_select_bus_o} === {2'b01, d, a}, "write pins");
            if (rsp_valid_o === 1'b1)
                q = rsp_rdata_o;
        end while (req_ready_o !== 1'b1 && n < 20);
        check(n < 20, "request never completed");
    endtask : req
    task automatic t_reset;
        @(negedge core_clk_i);
        check({sel_n_o, oe_n_o, we_n_o, bus_oe, req_ready_o} === 5'b11100, "reset pins");
    endtask : t_reset
    task automatic t_fill;
        for (int i = 0; i < 4; i++)
            req(1'b1, at[i], dt[i]);
        for (int i = 0; i < 4; i++)
        begin
            q = 4'hx;
            req(1'b0, at[i], 4'h0);
            check(q === dt[i], "read back");
        end
    endtask : t_fill
    task automatic t_overwrite;
        req(1'b1, 18'h00001, 4'h3);
        req(1'b1, 18'h00001, 4'hc);
        q = 4'hx;
        req(1'b0, 18'h00001, 4'h0);
        check(q === 4'hc, "overwrite");
    endtask : t_overwrite
    task automatic t_reread;
        q = 4'hx;
        req(1'b0, 18'h3ffff, 4'h0);
        check(q === 4'ha, "read top");
        req(1'b0, 18'h00000, 4'h0);
        check(q === 4'h5, "read after address change");
    endtask : t_reread
    initial
    begin
        #20000;
        fail_count++;
        end_sim();
    end
    initial
    begin
        repeat (5) @(posedge core_clk_i);
        t_reset();
        @(posedge core_clk_i);
        resetn_i <= 1'b1;
        t_fill();
        t_overwrite();
        t_reread();
        end_sim();
    end
endmodule : asrc_ctrl_bench
